// File: hw/cng_nmt_regs.svh
/*
 * Register offsets, reset values, codes and timing constants for the NMT/SYNC guard.
 * Assumes inclusion by bare name from the package and the bench.
 */
`ifndef CNG_NMT_REGS_SVH
`define CNG_NMT_REGS_SVH
// Summary of operation
// RULE1 - SYNC identifier register, reset 80h
// RULE2 - SYNC is a data-free timing event
// RULE3 - SYNC triggers synchronous PDO send or update
// RULE4 - Power-on enters init, then preoperational automatically
// RULE5 - Init takes part only in boot-up
// RULE6 - Boot-up: id 700h plus node, byte 0
// RULE7 - Preoperational: SDO, SYNC, EMCY, NMT; no PDO
// RULE8 - Operational all objects; stopped NMT only
// RULE9 - NMT command: id 00h, code, target
// RULE10 - Never reply to NMT commands
// RULE11 - Code 1 operational, code 2 stopped
// RULE12 - 128 preop, 129 full reset, 130 comm reset
// RULE13 - Target 0 or own node number
// RULE14 - Comm reset reinits communication objects only
// RULE15 - Timeout is guard time times factor
// RULE16 - Either value zero disables supervision
// RULE17 - Start on first request, restart each
// RULE18 - Guard request: remote frame, 700h plus node
// RULE19 - Answer byte: 4 stop, 5 op, 127 preop
// RULE20 - Bit 7 toggles on every answer
// RULE21 - Missing request within timeout raises error
// RULE22 - Master picks SYNC period with margin
// RULE23 - Type 0 once, 1-240 every Nth, 252 update; the code sends type 0 on every SYNC
// RULE24 - First toggle zero after reset
// RULE25 - Malformed commands and requests are ignored

// ****************************************
// Register map
// ****************************************
`define CNG_ADDR_GUARD   16'h100C
`define CNG_ADDR_LIFE    16'h100D
`define CNG_ADDR_SYNCID  16'h1015
`define CNG_ADDR_STATUS  16'h2000
`define CNG_RST_GUARD    32'h0000_0000
`define CNG_RST_LIFE     8'h00
`define CNG_RST_SYNCID   32'h0000_0080
`define CNG_STAT_LIFE    1
// ****************************************
// Identifiers and codes
// ****************************************
`define CNG_ID_NMT       11'h000
`define CNG_ID_GUARD     11'h700
`define CNG_CMD_START    8'h01
`define CNG_CMD_STOP     8'h02
`define CNG_CMD_PREOP    8'h80
`define CNG_CMD_RSTNODE  8'h81
`define CNG_CMD_RSTCOMM  8'h82
`define CNG_CODE_STOP    7'h04
`define CNG_CODE_OPER    7'h05
`define CNG_CODE_PREOP   7'h7F
`define CNG_TT_SYNC0     8'h00
`define CNG_TT_SYNCMAX   8'hF0
`define CNG_TT_RTRSYNC   8'hFC
// ****************************************
// Timing
// ****************************************
`define CNG_CLK_NS       20
`define CNG_MS_NS        1000000
`define CNG_MS_CYC       (`CNG_MS_NS / `CNG_CLK_NS)
`endif

// File: hw/cng_nmt_pkg.sv
/*
 * Types shared by the NMT/SYNC guard and its bench.
 * Assumes the constants header is on the include path.
 */
package cng_nmt_pkg;
	`include "cng_nmt_regs.svh"

	typedef enum logic [2:0] {
		ST_INIT,
		ST_BOOT,
		ST_PREOP,
		ST_OPER,
		ST_STOP
	} cng_state_e;

	typedef struct packed {
		logic [10:0] id;
		logic        rtr;
		logic [3:0]  dlc;
		logic [7:0]  b0;
		logic [7:0]  b1;
	} cng_frame_s;
endpackage

// File: hw/cng_nmt_guard.sv
/*
 * CANopen slave NMT state machine, SYNC consumer and node/life guarding.
 * Assumes a CAN controller on clk_sys that presents received frames as one-cycle
 * pulses and takes a transmit frame on a valid/ready handshake.
 */
module cng_nmt_guard
	import cng_nmt_pkg::*;
#(
	parameter int MS_CYCLES = `CNG_MS_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [15:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [6:0]  node_id_pin,
	input  wire logic        rx_valid,
	input  cng_frame_s       rx_frame,
	output cng_frame_s       tx_frame,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	input  wire logic [7:0]  tpdo_type,
	input  wire logic        tpdo_rtr,
	output logic             sync_event,
	output logic             tpdo_send,
	output logic             tpdo_update,
	output logic             pdo_en,
	output logic             sdo_en,
	output logic             emcy_en,
	output logic [6:0]       state_code,
	output logic             life_err,
	output logic             dev_reset,
	output logic             comm_reset
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [10:0] node_cob(input logic [10:0] base, input logic [6:0] node);
		node_cob = base + {4'h0, node};
	endfunction

	function automatic logic [6:0] code_of(input cng_state_e s);
		case (s)
			ST_OPER: code_of = `CNG_CODE_OPER;
			ST_STOP: code_of = `CNG_CODE_STOP;
			ST_PREOP: code_of = `CNG_CODE_PREOP;
			default: code_of = 7'h00;
		endcase
	endfunction

	cng_state_e  state_reg;
	logic [6:0]  node_sync1_reg;
	logic [6:0]  node_sync2_reg;
	logic [6:0]  node_reg;
	logic [31:0] guard_interval_ms_reg;
	logic [7:0]  life_factor_count_reg;
	logic [31:0] sync_message_identifier_reg;
	logic        toggle_reg;
	logic        tx_guard_reg;
	logic        armed_reg;
	logic        life_flag_reg;
	logic [31:0] ms_div_reg;
	logic [39:0] elapsed_reg;
	logic [7:0]  sync_cnt_reg;
	logic        tpdo_pend_reg;

	logic        live;
	logic        is_sync;
	logic        is_cmd;
	logic        is_guard;
	logic        reset_any;
	logic [39:0] limit;
	logic        ms_tick;

	// ****************************************
	// Frame decode
	// ****************************************
	assign live = (state_reg == ST_PREOP) || (state_reg == ST_OPER) || (state_reg == ST_STOP);
	// Data field of SYNC is not checked: only its arrival matters
	assign is_sync = rx_valid && live && (state_reg != ST_STOP) && !rx_frame.rtr //RULE2 RULE8
		&& (rx_frame.id == sync_message_identifier_reg[10:0]); //RULE1 RULE7
	assign is_cmd = rx_valid && live && !rx_frame.rtr && (rx_frame.id == `CNG_ID_NMT) //RULE9
		&& (rx_frame.dlc == 4'h2) //RULE25
		&& ((rx_frame.b1 == 8'h00) || (rx_frame.b1 == {1'b0, node_reg})); //RULE13
	assign is_guard = rx_valid && live && rx_frame.rtr //RULE18
		&& (rx_frame.id == node_cob(`CNG_ID_GUARD, node_reg))
		&& (rx_frame.dlc <= 4'h1); //RULE25
	assign reset_any = is_cmd && ((rx_frame.b0 == `CNG_CMD_RSTNODE)
		|| (rx_frame.b0 == `CNG_CMD_RSTCOMM));

	// ****************************************
	// Node number strap
	// ****************************************
	// No reset: the strap is through both stages by the first edge after release
	always_ff @(posedge clk_sys) begin
		node_sync1_reg <= node_id_pin;
		node_sync2_reg <= node_sync1_reg;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			node_reg <= 7'h00;
		end else if (state_reg == ST_INIT) begin
			node_reg <= node_sync2_reg;
		end
	end

	// ****************************************
	// Node state machine
	// ****************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_INIT; //RULE4
		end else begin
			case (state_reg)
				ST_INIT: state_reg <= ST_BOOT; //RULE4
				ST_BOOT: begin
					// A guard answer left over from before the reset is not the boot-up
					if (tx_valid && tx_ready && !tx_guard_reg) begin
						state_reg <= ST_PREOP; //RULE4
					end
				end
				default: begin
					if (is_cmd) begin
						case (rx_frame.b0)
							`CNG_CMD_START: state_reg <= ST_OPER; //RULE11
							`CNG_CMD_STOP: state_reg <= ST_STOP; //RULE11
							`CNG_CMD_PREOP: state_reg <= ST_PREOP; //RULE12
							`CNG_CMD_RSTNODE: state_reg <= ST_INIT; //RULE12
							`CNG_CMD_RSTCOMM: state_reg <= ST_INIT; //RULE12 RULE14
							default: state_reg <= state_reg; //RULE25
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dev_reset  <= 1'b0;
			comm_reset <= 1'b0;
		end else begin
			dev_reset  <= is_cmd && (rx_frame.b0 == `CNG_CMD_RSTNODE); //RULE12
			comm_reset <= reset_any; //RULE14
		end
	end

	// Object gating per state
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pdo_en     <= 1'b0;
			sdo_en     <= 1'b0;
			emcy_en    <= 1'b0;
			state_code <= 7'h00;
		end else begin
			pdo_en     <= (state_reg == ST_OPER); //RULE7 RULE8
			sdo_en     <= (state_reg == ST_OPER) || (state_reg == ST_PREOP); //RULE7
			emcy_en    <= (state_reg == ST_OPER) || (state_reg == ST_PREOP); //RULE8
			state_code <= code_of(state_reg);
		end
	end

	// ****************************************
	// Communication objects
	// ****************************************
	// Both reset commands clear these; the rest of the device is left to dev_reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			guard_interval_ms_reg       <= `CNG_RST_GUARD;
			life_factor_count_reg       <= `CNG_RST_LIFE;
			sync_message_identifier_reg <= `CNG_RST_SYNCID; //RULE1
		end else if (reset_any) begin
			guard_interval_ms_reg       <= `CNG_RST_GUARD; //RULE14
			life_factor_count_reg       <= `CNG_RST_LIFE;
			sync_message_identifier_reg <= `CNG_RST_SYNCID;
		end else if (reg_wr) begin
			case (reg_addr)
				`CNG_ADDR_GUARD: guard_interval_ms_reg <= reg_wdata; //RULE15
				`CNG_ADDR_LIFE: life_factor_count_reg <= reg_wdata[7:0]; //RULE15
				`CNG_ADDR_SYNCID: sync_message_identifier_reg <= reg_wdata; //RULE1
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`CNG_ADDR_GUARD: reg_rdata <= guard_interval_ms_reg;
				`CNG_ADDR_LIFE: reg_rdata <= {24'h00_0000, life_factor_count_reg};
				`CNG_ADDR_SYNCID: reg_rdata <= sync_message_identifier_reg;
				`CNG_ADDR_STATUS: reg_rdata <= {16'h0000, 1'b0, code_of(state_reg),
					5'h00, toggle_reg, life_flag_reg, armed_reg};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Transmit: boot-up and guard answers
	// ****************************************
	// One frame slot; a guard request that meets a busy slot is dropped
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_valid     <= 1'b0;
			tx_guard_reg <= 1'b0;
			tx_frame     <= '0;
		end else if (tx_valid) begin
			if (tx_ready) begin
				tx_valid <= 1'b0;
			end
		end else if ((state_reg == ST_INIT) || (state_reg == ST_BOOT)) begin
			tx_valid          <= 1'b1; //RULE5 RULE6
			tx_guard_reg      <= 1'b0;
			tx_frame.id       <= node_cob(`CNG_ID_GUARD, node_sync2_reg); //RULE6
			tx_frame.rtr      <= 1'b0;
			tx_frame.dlc      <= 4'h1;
			tx_frame.b0       <= 8'h00; //RULE6
			tx_frame.b1       <= 8'h00;
		end else if (is_guard) begin //RULE10
			tx_valid          <= 1'b1;
			tx_guard_reg      <= 1'b1;
			tx_frame.id       <= node_cob(`CNG_ID_GUARD, node_reg);
			tx_frame.rtr      <= 1'b0;
			tx_frame.dlc      <= 4'h1;
			tx_frame.b0       <= {toggle_reg, code_of(state_reg)}; //RULE19 RULE20
			tx_frame.b1       <= 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			toggle_reg <= 1'b0; //RULE24
		end else if ((state_reg == ST_INIT) || (state_reg == ST_BOOT)) begin
			toggle_reg <= 1'b0; //RULE24
		end else if (tx_valid && tx_ready && tx_guard_reg) begin
			toggle_reg <= !toggle_reg; //RULE20
		end
	end

	// ****************************************
	// Life guarding
	// ****************************************
	assign limit   = guard_interval_ms_reg * {32'h0000_0000, life_factor_count_reg}; //RULE15
	assign ms_tick = (ms_div_reg == 32'(MS_CYCLES - 1));

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			armed_reg   <= 1'b0;
			ms_div_reg  <= 32'h0000_0000;
			elapsed_reg <= 40'h00_0000_0000;
			life_err    <= 1'b0;
		end else begin
			life_err <= 1'b0;
			if ((limit == 40'h00_0000_0000) || (state_reg == ST_INIT)) begin
				armed_reg <= 1'b0; //RULE16
			end else if (is_guard) begin
				armed_reg   <= 1'b1; //RULE17
				ms_div_reg  <= 32'h0000_0000;
				elapsed_reg <= 40'h00_0000_0000; //RULE17
			end else if (armed_reg) begin
				ms_div_reg <= ms_tick ? 32'h0000_0000 : ms_div_reg + 32'h0000_0001;
				if (ms_tick) begin
					if (elapsed_reg + 40'h00_0000_0001 >= limit) begin
						life_err  <= 1'b1; //RULE21
						armed_reg <= 1'b0;
					end else begin
						elapsed_reg <= elapsed_reg + 40'h00_0000_0001;
					end
				end
			end
		end
	end

	// Sticky copy; an error in the clearing cycle survives
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			life_flag_reg <= 1'b0;
		end else if (life_err) begin
			life_flag_reg <= 1'b1; //RULE21
		end else if (reg_wr && (reg_addr == `CNG_ADDR_STATUS)
			&& reg_wdata[`CNG_STAT_LIFE]) begin
			life_flag_reg <= 1'b0;
		end
	end

	// ****************************************
	// SYNC consumer and synchronous PDO trigger
	// ****************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync_event    <= 1'b0;
			tpdo_send     <= 1'b0;
			tpdo_update   <= 1'b0;
			sync_cnt_reg  <= 8'h00;
			tpdo_pend_reg <= 1'b0;
		end else begin
			sync_event  <= is_sync; //RULE2
			tpdo_send   <= 1'b0;
			tpdo_update <= 1'b0;
			if (state_reg != ST_OPER) begin
				sync_cnt_reg  <= 8'h00; //RULE7
				tpdo_pend_reg <= 1'b0;
			end else if (is_sync) begin
				if (tpdo_type == `CNG_TT_SYNC0) begin
					tpdo_send <= 1'b1; //RULE3 RULE23
				end else if (tpdo_type <= `CNG_TT_SYNCMAX) begin
					if (sync_cnt_reg + 8'h01 >= tpdo_type) begin
						tpdo_send    <= 1'b1; //RULE23
						sync_cnt_reg <= 8'h00;
					end else begin
						sync_cnt_reg <= sync_cnt_reg + 8'h01;
					end
				end else if (tpdo_type == `CNG_TT_RTRSYNC) begin
					tpdo_update   <= 1'b1; //RULE23
					tpdo_pend_reg <= 1'b1;
				end
			end else if (tpdo_rtr && tpdo_pend_reg) begin
				tpdo_send     <= 1'b1; //RULE23
				tpdo_pend_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sync_reset_val_a: assert property (@(posedge clk_sys) //RULE1
		$rose(reset_n) |-> sync_message_identifier_reg == `CNG_RST_SYNCID)
		else $error("SYNC id not at reset value");

	sync_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE2
		is_sync |=> sync_event)
		else $error("SYNC event missed");

	init_to_boot_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE4
		reset_n && state_reg == ST_INIT |=> state_reg == ST_BOOT ##0 tx_valid)
		else $error("Init did not queue boot-up");

	boot_frame_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE6
		state_reg == ST_BOOT && tx_valid |-> tx_frame.dlc == 4'h1 && tx_frame.b0 == 8'h00
		&& tx_frame.id == node_cob(`CNG_ID_GUARD, node_reg))
		else $error("Bad boot-up frame");

	pdo_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE7
		state_reg == ST_PREOP ##1 state_reg == ST_PREOP |-> !pdo_en && !tpdo_send)
		else $error("PDO active in preoperational");

	stop_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE8
		$past(state_reg) == ST_STOP |-> !sdo_en && !emcy_en && !sync_event)
		else $error("Object active in stopped");

	start_cmd_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE11
		is_cmd && rx_frame.b0 == `CNG_CMD_START |=> state_reg == ST_OPER ##1 pdo_en)
		else $error("Start command not obeyed");

	no_reply_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE10
		is_cmd && !tx_valid && !is_guard && state_reg != ST_INIT |=> !tx_valid)
		else $error("Frame sent after NMT command");

	comm_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE14
		is_cmd && rx_frame.b0 == `CNG_CMD_RSTCOMM |=> comm_reset && !dev_reset
		&& state_reg == ST_INIT && guard_interval_ms_reg == `CNG_RST_GUARD)
		else $error("Communication reset incomplete");

	guard_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE16
		limit == 40'h00_0000_0000 |=> !life_err)
		else $error("Life error while disabled");

	guard_answer_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE19
		is_guard && !tx_valid |=> tx_valid && tx_frame.b0 == {$past(toggle_reg),
		$past(code_of(state_reg))})
		else $error("Bad guard answer");

	toggle_flip_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE20
		tx_valid && tx_ready && tx_guard_reg |=> toggle_reg != $past(toggle_reg))
		else $error("Toggle bit did not invert");

	bad_cmd_a: assert property (@(posedge clk_sys) disable iff (!reset_n) //RULE25
		rx_valid && rx_frame.id == `CNG_ID_NMT && rx_frame.dlc != 4'h2
		&& state_reg != ST_BOOT && state_reg != ST_INIT |=> $stable(state_reg))
		else $error("Malformed command changed state");

endmodule

// File: dv/cng_nmt_master.sv
/*
 * Network master model: sends frames to the node, takes its transmit frames.
 * Assumes the bench calls send and sets stall for the acceptance delay.
 */
module cng_nmt_master
	import cng_nmt_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  cng_frame_s tx_frame,
	input  wire logic tx_valid,
	output logic      tx_ready,
	output logic      rx_valid,
	output cng_frame_s rx_frame
);
	timeunit 1ns;
	timeprecision 1ps;
	int         stall;
	int         wait_cnt;
	cng_frame_s got[$];
	// ****************************************
	// Frames towards the node
	// ****************************************
	initial begin
		rx_valid = 1'b0;
		rx_frame = '0;
		stall = 0;
	end
	// After the pulse the lines carry junk, so a stale frame never looks valid
	task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
		input logic [7:0] b0, input logic [7:0] b1);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_frame <= '{id, rtr, dlc, b0, b1};
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_frame <= ~rx_frame;
	endtask
	// ****************************************
	// Frames from the node
	// ****************************************
	// Stall lets a slow controller be imitated
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_ready <= 1'b0;
			wait_cnt <= 0;
		end else if (tx_valid && tx_ready) begin
			got.push_back(tx_frame);
			tx_ready <= 1'b0;
			wait_cnt <= 0;
		end else if (tx_valid) begin
			tx_ready <= (wait_cnt >= stall);
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

// File: dv/test_canopen_nmt_sync_guard.sv
/*
 * Self-checking bench for the NMT/SYNC guard with a master model.
 * Assumes the package, constants header and master model are compiled first.
 */
`include "cng_nmt_regs.svh"
module test_canopen_nmt_sync_guard
	import cng_nmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 10;
	logic        clk_sys, reset_n, reg_wr, reg_rd, tpdo_rtr, tx_valid, tx_ready, rx_valid, tog;
	logic        sync_event, tpdo_send, tpdo_update, pdo_en, sdo_en, emcy_en;
	logic        life_err, dev_reset, comm_reset;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [6:0]  node_id_pin, state_code, node;
	logic [7:0]  tpdo_type;
	logic [10:0] sid;
	cng_frame_s  rx_frame, tx_frame;
	int          mismatches, n_compared, seed, n, tick, t_req, t_life;
	int          n_sync, n_send, n_upd, n_life, n_dev, n_comm, b_sync, b_send, b_upd, b_life;
	int          codes[4] = '{1, 2, 128, 1};
	int          exps[4] = '{5, 4, 127, 5};

	cng_nmt_guard #(.MS_CYCLES(MS)) i_cng_nmt_guard (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .node_id_pin, .rx_valid, .rx_frame, .tx_frame, .tx_valid,
		.tx_ready, .tpdo_type, .tpdo_rtr, .sync_event, .tpdo_send, .tpdo_update, .pdo_en,
		.sdo_en, .emcy_en, .state_code, .life_err, .dev_reset, .comm_reset);
	cng_nmt_master i_cng_nmt_master (.clk_sys, .reset_n, .tx_frame, .tx_valid, .tx_ready,
		.rx_valid, .rx_frame);

	// ****************************************
	// Clock and pulse counters
	// ****************************************
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		tick++;
		n_sync += (sync_event === 1'b1);
		n_send += (tpdo_send === 1'b1);
		n_upd += (tpdo_update === 1'b1);
		n_dev += (dev_reset === 1'b1);
		n_comm += (comm_reset === 1'b1);
		if (life_err === 1'b1) begin
			n_life++;
			t_life = tick;
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= $random(seed);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check(what, reg_rdata, exp);
	endtask
	function automatic logic [10:0] guard_id(input logic [6:0] nd);
		guard_id = 11'h700 + {4'h0, nd};
	endfunction
	// Bounded wait for the master to take frame number k
	task automatic wait_tx(input int k);
		for (int i = 0; i < 200 && i_cng_nmt_master.got.size() <= k; i++) @(posedge clk_sys);
		#1;
	endtask
	task automatic boot(input int k);
		wait_tx(k);
		check("boot id", i_cng_nmt_master.got[k].id, guard_id(node));
		check("boot dlc", i_cng_nmt_master.got[k].dlc, 4'd1);
		check("boot byte", i_cng_nmt_master.got[k].b0, 8'h00);
		tog = 1'b0;
	endtask
	task automatic guard_req(input logic [6:0] code);
		int k;
		k = i_cng_nmt_master.got.size();
		i_cng_nmt_master.send(guard_id(node), 1'b1, 4'd0, $random(seed), $random(seed));
		#1;
		t_req = tick;
		wait_tx(k);
		check("guard id", i_cng_nmt_master.got[k].id, guard_id(node));
		check("guard dlc", i_cng_nmt_master.got[k].dlc, 4'd1);
		check("guard byte", i_cng_nmt_master.got[k].b0, {tog, code});
		tog = ~tog;
	endtask
	task automatic nmt(input logic [7:0] code, input logic [7:0] tgt, input logic [3:0] dlc);
		i_cng_nmt_master.send(11'h000, 1'b0, dlc, code, tgt);
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic st(input int exp);
		check("state", state_code, exp);
		check("pdo en", pdo_en, exp == 5);
		check("sdo en", sdo_en, exp == 5 || exp == 127);
		check("emcy en", emcy_en, exp == 5 || exp == 127);
	endtask
	task automatic sync(input int k);
		b_sync = n_sync;
		b_send = n_send;
		b_upd = n_upd;
		repeat (k) i_cng_nmt_master.send(sid, 1'b0, 4'd0, $random(seed), $random(seed));
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic final_report();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		#600000;
		mismatches++;
		final_report();
	end
	initial begin
		seed = 32'h5b0e;
		{clk_sys, reset_n, reg_wr, reg_rd, tpdo_rtr, tog} = '0;
		{reg_addr, reg_wdata, tpdo_type} = '0;
		node = 7'd1 + 7'({$random(seed)} % 126);
		node_id_pin = node;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(`CNG_ADDR_SYNCID, `CNG_RST_SYNCID, "sync id reset");
		rd(`CNG_ADDR_GUARD, `CNG_RST_GUARD, "guard reset");
		rd(`CNG_ADDR_LIFE, 32'(`CNG_RST_LIFE), "life reset");
		rd(16'h1234, 32'h0000_0000, "unmapped");
		boot(0);
		repeat (3) @(posedge clk_sys);
		#1;
		st(127);
		i_cng_nmt_master.stall = {$random(seed)} % 4;
		guard_req(7'h7F);
		for (int i = 0; i < 4; i++) begin
			n = i_cng_nmt_master.got.size();
			nmt(8'(codes[i]), (i % 2) ? {1'b0, node} : 8'h00, 4'd2);
			st(exps[i]);
			check("no reply", i_cng_nmt_master.got.size(), n);
			guard_req(7'(exps[i]));
		end
		nmt(8'h02, {1'b0, node} + 8'h01, 4'd2);
		nmt(8'h02, 8'h00, 4'd1);
		nmt(8'h05, 8'h00, 4'd2);
		st(5);
		sid = 11'h100 | 11'($random(seed) & 32'h0000_00FF);
		wr(`CNG_ADDR_SYNCID, 32'(sid));
		rd(`CNG_ADDR_SYNCID, 32'(sid), "sync id");
		i_cng_nmt_master.send(11'h080, 1'b0, 4'd0, 8'h00, 8'h00);
		sync(2);
		check("sync events", n_sync - b_sync, 2);
		check("type 0 sends", n_send - b_send, 2);
		tpdo_type <= 8'd3;
		sync(6);
		check("type 3 sends", n_send - b_send, 2);
		tpdo_type <= `CNG_TT_RTRSYNC;
		sync(2);
		check("updates", n_upd - b_upd, 2);
		check("no send", n_send - b_send, 0);
		@(posedge clk_sys);
		tpdo_rtr <= 1'b1;
		@(posedge clk_sys);
		tpdo_rtr <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check("rtr send", n_send - b_send, 1);
		nmt(8'h02, 8'h00, 4'd2);
		sync(1);
		check("sync in stop", n_sync - b_sync, 0);
		wr(`CNG_ADDR_GUARD, 32'd3);
		wr(`CNG_ADDR_LIFE, 32'd2);
		rd(`CNG_ADDR_LIFE, 32'd2, "life factor");
		b_life = n_life;
		repeat (100) @(posedge clk_sys);
		check("not armed", n_life - b_life, 0);
		guard_req(7'h04);
		repeat (100) @(posedge clk_sys);
		check("life error", n_life - b_life, 1);
		check("timeout", (t_life - t_req >= 6 * MS) && (t_life - t_req <= 6 * MS + 2), 1);
		rd(`CNG_ADDR_STATUS, {17'h0, 7'h04, 5'h0, tog, 2'b10}, "status");
		wr(`CNG_ADDR_STATUS, 32'h0000_0002);
		rd(`CNG_ADDR_STATUS, {17'h0, 7'h04, 5'h0, tog, 2'b00}, "cleared");
		wr(`CNG_ADDR_LIFE, 32'd0);
		b_life = n_life;
		guard_req(7'h04);
		repeat (150) @(posedge clk_sys);
		check("disabled", n_life - b_life, 0);
		b_send = n_comm;
		b_upd = n_dev;
		n = i_cng_nmt_master.got.size();
		nmt(8'h82, {1'b0, node}, 4'd2);
		boot(n);
		check("comm reset", n_comm - b_send, 1);
		check("no dev reset", n_dev - b_upd, 0);
		rd(`CNG_ADDR_SYNCID, `CNG_RST_SYNCID, "sync id again");
		st(127);
		guard_req(7'h7F);
		n = i_cng_nmt_master.got.size();
		nmt(8'h81, 8'h00, 4'd2);
		boot(n);
		check("dev reset", n_dev - b_upd, 1);
		final_report();
	end
endmodule
